/* File: verilog/out_div_pkg.sv */
`default_nettype none
package out_div_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int         ADDR_W        = 8;
  localparam int         DATA_W        = 16;
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] OUT_A_OFS     = 8'h04;
  localparam logic [7:0] OUT_B_OFS     = 8'h08;
  localparam logic [7:0] DIV_OFS       = 8'h0c;
  localparam logic [7:0] STATUS_OFS    = 8'h10;
  localparam logic [7:0] EVCOUNT_OFS   = 8'h14;

  // control register fields
  localparam int CAL_TRIG_BIT   = 0;
  localparam int PDOWN_BIT      = 1;
  localparam int ALIGN_MODE_BIT = 2;

  // output register fields
  localparam int LEVEL_LSB   = 0;
  localparam int LEVEL_W     = 6;
  localparam int OUT_DIS_BIT = 6;
  localparam int SRC_LSB     = 7;

  // divider register fields
  localparam int SEL_LSB      = 0;
  localparam int SEL_W        = 5;
  localparam int PIN_MASK_BIT = 5;

  // status register fields
  localparam int ST_DIV_PWR_BIT = 0;
  localparam int ST_VALID_BIT   = 1;
  localparam int ST_ACTIVE_BIT  = 2;
  localparam int ST_RECAL_BIT   = 3;
  localparam int ST_ALIGNED_BIT = 4;
  localparam int ST_EXTRA_LSB   = 5;
  localparam int ST_TOTAL_LSB   = 8;

  // output source encodings
  typedef enum logic [1:0] {SRC_DIVIDER, SRC_VCO, SRC_FRAME_REF, SRC_NONE} source_t;

  // reset values
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [15:0] OUT_RST   = 16'h009f; // source vco, level 31
  localparam logic [15:0] DIV_RST   = 16'h0020; // select 0, pin masked

  // divider decode
  localparam logic [4:0] SEL_LAST_VALID = 5'h0c;
  localparam logic [7:0] TOTAL_24       = 8'h18;
  localparam logic [7:0] TOTAL_192      = 8'hc0;
  localparam logic [2:0] EXTRA_ONE      = 3'h1;
  localparam logic [2:0] EXTRA_FOUR     = 3'h4;
  localparam logic [2:0] EXTRA_SIX      = 3'h6;

  // phase settling time after an alignment event
  localparam int SETTLE_NS     = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

/* File: verilog/divide_stage_decode.sv */
`timescale 1ns/1ns
`default_nettype none
module divide_stage_decode
  import out_div_pkg::*;
(
  input  wire logic [4:0] divider_select,       // 5-bit divider code
  output logic      [1:0] divide_stage_first,   // always 2
  output logic      [1:0] divide_stage_second,  // 1, 2 or 3
  output logic      [3:0] divide_stage_third,   // 1 to 8
  output logic      [2:0] divide_stage_fourth,  // 1 to 4
  output logic      [7:0] divide_total,         // product of the stages
  output logic            select_valid          // code in 0..12
);
  // ---------------------------------------------------------------
  // segment table
  // ---------------------------------------------------------------
  logic [7:0] prod;

  always_comb
  begin
    divide_stage_first  = 2'd2;
    divide_stage_second = 2'd2;
    divide_stage_third  = 4'd1;
    divide_stage_fourth = 3'd1;
    select_valid        = 1'b1;
    // [RL2] code to segment decode
    case (divider_select)
      5'h00: divide_stage_second = 2'd1;
      5'h01: ;
      5'h02: divide_stage_second = 2'd3;
      5'h03: divide_stage_third  = 4'd2;
      5'h04: begin divide_stage_second = 2'd3; divide_stage_third = 4'd2; end
      5'h05: divide_stage_third  = 4'd4;
      5'h06: begin divide_stage_second = 2'd3; divide_stage_third = 4'd4; end
      5'h07: divide_stage_third  = 4'd8;
      5'h08: begin divide_stage_second = 2'd3; divide_stage_third = 4'd8; end
      5'h09: begin divide_stage_third = 4'd8; divide_stage_fourth = 3'd2; end
      5'h0a:
      begin
        divide_stage_second = 2'd3;
        divide_stage_third  = 4'd8;
        divide_stage_fourth = 3'd2;
      end
      5'h0b: begin divide_stage_third = 4'd8; divide_stage_fourth = 3'd4; end
      5'h0c:
      begin
        divide_stage_second = 2'd3;
        divide_stage_third  = 4'd8;
        divide_stage_fourth = 3'd4;
      end
      default:
      begin
        // invalid codes keep the smallest ratio rather than garbage
        divide_stage_second = 2'd1;
        select_valid        = 1'b0;
      end
    endcase
  end

  // [RL1] total is the stage product
  always_comb
  begin
    prod = 8'(divide_stage_first * divide_stage_second * divide_stage_third
              * divide_stage_fourth);
    divide_total = prod;
  end
endmodule // divide_stage_decode
`default_nettype wire

/* File: verilog/output_divider_and_phase_align.sv */
`timescale 1ns/1ns
`default_nettype none
// Contract
// [RL1] divider is four cascaded stages, total equals their product
// [RL2] decode 5-bit select per table; codes 13 to 31 invalid
// [RL3] host picks totals of 32 or more only at low oscillator rates
// [RL4] divider powered when A selects divider or B divider/frame-ref
// [RL5] host routes unused outputs to the oscillator source
// [RL6] output level or disable changes never disturb lock
// [RL7] host limits level to 31 (5-10 GHz) or 20 (above)
// [RL8] power-down by enable pin or power-down bit
// [RL9] host rewrites control with calibrate trigger after power-up
// [RL10] sync request registered on next reference rising edge
// [RL11] phase becomes deterministic after a settling interval
// [RL12] align mode, both outputs vco: extra feedback divide 1
// [RL13] else extra divide 6 if total divisible by 3, not 24/192; else 4
// [RL14] host may sync in software by raising align mode bit
// [RL15] each control write with calibrate trigger starts calibration
// [RL16] host masks the sync pin when align mode is off
// [RL17] one alignment event per sync pin rising edge on reference clock
module output_divider_and_phase_align
  import out_div_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES                // settle count after alignment
)(
  input  wire logic                      sys_clk,      // 100 MHz system clock
  input  wire logic                      resetn,       // async reset, active low
  input  wire logic [out_div_pkg::ADDR_W-1:0] reg_addr, // register byte address
  input  wire logic [out_div_pkg::DATA_W-1:0] reg_wdata, // register write data
  input  wire logic                      reg_wr,       // write strobe
  input  wire logic                      reg_rd,       // read strobe
  output logic [out_div_pkg::DATA_W-1:0] reg_rdata,    // read data, cycle after strobe
  input  wire logic                      enable_pin,   // chip enable pin, high = on
  input  wire logic                      sync_pin,     // synchronization request pin
  input  wire logic                      reference_clock_in, // reference oscillator
  output logic                           device_active, // not powered down
  output logic                           divider_powered, // output divider power
  output logic [4:0]                     divider_select,  // current select code
  output logic [7:0]                     divide_total,    // decoded total
  output logic                           select_valid,    // select code legal
  output logic [2:0]                     feedback_extra_divide, // 1, 4 or 6
  output logic [5:0]                     output_a_level,  // output A level
  output logic                           output_a_on,     // output A enabled
  output logic [5:0]                     output_b_level,  // output B level
  output logic                           output_b_on,     // output B enabled
  output logic                           calibrate_start, // one-cycle pulse
  output logic                           align_event,     // one-cycle pulse
  output logic                           phase_aligned    // phase settled
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] ctrl_q, out_a_q, out_b_q, div_q;
  logic [15:0] rdata_q;
  logic        cal_q, recal_need_q, active_q, act_prev_q;
  logic [1:0]  first_s;
  logic [1:0]  second_s;
  logic [3:0]  third_s;
  logic [2:0]  fourth_s;
  logic [7:0]  total_s;
  logic        valid_s;
  logic [2:0]  extra_d;
  logic        div_pwr_d;
  logic        ref_s1_q, ref_s2_q, ref_s3_q;
  logic        sync_s1_q, sync_s2_q, sync_smp_q;
  logic        pin_event_q, sw_event_q;
  logic [7:0]  event_count_q;
  logic [15:0] settle_q;
  logic        aligned_q;

  wire logic   wr_ctrl   = reg_wr && (reg_addr == CTRL_OFS);
  wire logic   align_on  = ctrl_q[ALIGN_MODE_BIT];
  wire logic   ref_rise  = ref_s2_q && !ref_s3_q;
  wire source_t src_a    = source_t'(out_a_q[SRC_LSB +: 2]);
  wire source_t src_b    = source_t'(out_b_q[SRC_LSB +: 2]);

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q  <= CTRL_RST;
      out_a_q <= OUT_RST;
      out_b_q <= OUT_RST;
      div_q   <= DIV_RST;
    end
    else if (reg_wr)
    begin
      // [RL6] output writes only touch output fields
      case (reg_addr)
        CTRL_OFS:  ctrl_q  <= reg_wdata;
        OUT_A_OFS: out_a_q <= reg_wdata;
        OUT_B_OFS: out_b_q <= reg_wdata;
        DIV_OFS:   div_q   <= reg_wdata;
        default:   ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // calibration and power
  // ---------------------------------------------------------------
  // [RL15] calibration pulse on trigger write
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      cal_q <= 1'b0;
    else
      cal_q <= wr_ctrl && reg_wdata[CAL_TRIG_BIT];
  end

  logic en_s1_q, en_s2_q;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      en_s1_q    <= 1'b0;
      en_s2_q    <= 1'b0;
      active_q   <= 1'b0;
      act_prev_q <= 1'b0;
    end
    else
    begin
      en_s1_q    <= enable_pin;
      en_s2_q    <= en_s1_q;
      // [RL8] pin or bit powers down
      active_q   <= en_s2_q && !ctrl_q[PDOWN_BIT];
      act_prev_q <= active_q;
    end
  end

  // leaving power-down leaves the loop uncalibrated until software retriggers;
  // a wake-up in the same cycle as the calibrate pulse still flags the need
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      recal_need_q <= 1'b0;
    else if (active_q && !act_prev_q)
      recal_need_q <= 1'b1;
    else if (cal_q)
      recal_need_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // divider decode and feedback divide
  // ---------------------------------------------------------------
  divide_stage_decode u_decode (
    .divider_select      (div_q[SEL_LSB +: SEL_W]),
    .divide_stage_first  (first_s),
    .divide_stage_second (second_s),
    .divide_stage_third  (third_s),
    .divide_stage_fourth (fourth_s),
    .divide_total        (total_s),
    .select_valid        (valid_s)
  );

  always_comb
  begin
    // [RL4] divider power from the two sources
    div_pwr_d = (src_a == SRC_DIVIDER) || (src_b == SRC_DIVIDER)
                || (src_b == SRC_FRAME_REF);
    extra_d = EXTRA_ONE;
    if (align_on && !(src_a == SRC_VCO && src_b == SRC_VCO))
    begin
      // [RL13] six or four by total
      if (valid_s && (total_s % 8'd3 == 8'd0) && total_s != TOTAL_24
          && total_s != TOTAL_192)
        extra_d = EXTRA_SIX;
      else
        extra_d = EXTRA_FOUR;
    end
  end

  // ---------------------------------------------------------------
  // sync capture
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ref_s1_q  <= 1'b0;
      ref_s2_q  <= 1'b0;
      ref_s3_q  <= 1'b0;
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
    end
    else
    begin
      ref_s1_q  <= reference_clock_in;
      ref_s2_q  <= ref_s1_q;
      ref_s3_q  <= ref_s2_q;
      sync_s1_q <= sync_pin;
      sync_s2_q <= sync_s1_q;
    end
  end

  // sync level is only looked at on reference edges, so a pulse shorter
  // than one reference period can be missed
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync_smp_q  <= 1'b0;
      pin_event_q <= 1'b0;
    end
    else
    begin
      // [RL10] request taken on reference edge
      if (ref_rise)
        sync_smp_q <= sync_s2_q;
      // [RL17] one event per sampled edge
      pin_event_q <= ref_rise && sync_s2_q && !sync_smp_q && align_on
                     && !div_q[PIN_MASK_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      sw_event_q <= 1'b0;
    else
      sw_event_q <= wr_ctrl && reg_wdata[ALIGN_MODE_BIT] && !align_on;
  end

  // [RL11] settle before phase is deterministic
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      settle_q      <= 16'h0000;
      aligned_q     <= 1'b0;
      event_count_q <= 8'h00;
    end
    else if (pin_event_q || sw_event_q)
    begin
      settle_q      <= 16'(SETTLE);
      aligned_q     <= 1'b0;
      event_count_q <= event_count_q + 8'h01;
    end
    else if (cal_q)
      settle_q <= 16'(SETTLE);
    else if (settle_q != 16'h0000)
    begin
      settle_q <= settle_q - 16'h0001;
      if (settle_q == 16'h0001)
        aligned_q <= align_on;
    end
    else if (!align_on)
      aligned_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      divider_powered       <= 1'b0;
      feedback_extra_divide <= EXTRA_ONE;
    end
    else
    begin
      divider_powered       <= div_pwr_d;
      // [RL12] vco-only keeps divide of one
      feedback_extra_divide <= extra_d;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        CTRL_OFS:    rdata_q <= ctrl_q;
        OUT_A_OFS:   rdata_q <= out_a_q;
        OUT_B_OFS:   rdata_q <= out_b_q;
        DIV_OFS:     rdata_q <= div_q;
        STATUS_OFS:  rdata_q <= {total_s, feedback_extra_divide, aligned_q, recal_need_q,
                                 active_q, valid_s, divider_powered};
        EVCOUNT_OFS: rdata_q <= {8'h00, event_count_q};
        default:     rdata_q <= 16'h0000;
      endcase
    end
    else
      rdata_q <= 16'h0000;
  end

  assign reg_rdata       = rdata_q;
  assign device_active   = active_q;
  assign divider_select  = div_q[SEL_LSB +: SEL_W];
  assign divide_total    = total_s;
  assign select_valid    = valid_s;
  assign output_a_level  = out_a_q[LEVEL_LSB +: LEVEL_W];
  assign output_a_on     = !out_a_q[OUT_DIS_BIT];
  assign output_b_level  = out_b_q[LEVEL_LSB +: LEVEL_W];
  assign output_b_on     = !out_b_q[OUT_DIS_BIT];
  assign calibrate_start = cal_q;
  assign align_event     = pin_event_q || sw_event_q;
  assign phase_aligned   = aligned_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  stage_product_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL1]
    divide_total == 8'(first_s * second_s * third_s * fourth_s))
    else $error("total differs from stage product");
  invalid_code_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL2]
    (divider_select > SEL_LAST_VALID) |-> !select_valid)
    else $error("invalid select reported valid");
  div_power_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL4]
    (src_a == SRC_VCO && src_b == SRC_VCO) |=> !divider_powered)
    else $error("divider powered with vco sources");
  level_no_cal_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL6]
    (reg_wr && (reg_addr == OUT_A_OFS || reg_addr == OUT_B_OFS)) |=> !calibrate_start)
    else $error("output write started calibration");
  pin_down_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL8]
    !enable_pin [*3] |=> !device_active)
    else $error("device active with enable pin low");
  pin_on_ref_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL10]
    pin_event_q |-> $past(ref_rise))
    else $error("pin event not on reference edge");
  settle_wait_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL11]
    align_event |=> !phase_aligned [*2])
    else $error("aligned too soon after event");
  vco_extra_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL12]
    (align_on && src_a == SRC_VCO && src_b == SRC_VCO) |=> feedback_extra_divide == EXTRA_ONE)
    else $error("extra divide not one for vco");
  six_extra_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL13]
    (align_on && src_a == SRC_DIVIDER && valid_s && total_s == 8'h0c)
      |=> feedback_extra_divide == EXTRA_SIX)
    else $error("extra divide not six");
  cal_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL15]
    (wr_ctrl && reg_wdata[CAL_TRIG_BIT]) |=> calibrate_start
      ##1 (calibrate_start == $past(wr_ctrl && reg_wdata[CAL_TRIG_BIT])))
    else $error("calibration pulse wrong");
  one_event_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL17]
    pin_event_q |=> !pin_event_q)
    else $error("double event per edge");
endmodule // output_divider_and_phase_align
`default_nettype wire

/* File: test/ref_osc_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ref_osc_model #(
  parameter int HALF_NS = 50                // 10 MHz reference
)(
  input  wire logic sync_req,               // host asks for a sync edge
  output logic      reference_clock_in,     // free-running reference
  output logic      sync_pin                // sync request pin
);
  // ----------------------------------------------------------------
  // reference oscillator
  // ----------------------------------------------------------------
  // runs free: a reference oscillator never stops between syncs
  initial reference_clock_in = 1'b0;
  always #(HALF_NS) reference_clock_in = ~reference_clock_in;

  // ----------------------------------------------------------------
  // sync pin driver
  // ----------------------------------------------------------------
  // moves on the falling reference edge so setup and hold around the
  // sampling rise are both half a period; pin idles low like a pull-down
  initial sync_pin = 1'b0;
  always @(negedge reference_clock_in) sync_pin <= sync_req;
endmodule // ref_osc_model
`default_nettype wire

/* File: test/output_divider_and_phase_align_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module output_divider_and_phase_align_tb_top;
  import out_div_pkg::*;
  localparam int SETTLE_TB = 4;
  logic        sys_clk     = 1'b0;
  logic        resetn      = 1'b0;
  logic [7:0]  reg_addr    = 8'h00;
  logic [15:0] reg_wdata   = 16'h0000;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic        enable_pin  = 1'b1;
  logic        sync_req    = 1'b0;
  logic [15:0] reg_rdata;
  logic        sync_pin;
  logic        reference_clock_in;
  logic        device_active;
  logic        divider_powered;
  logic        select_valid;
  logic [4:0]  divider_select;
  logic [7:0]  divide_total;
  logic [2:0]  feedback_extra_divide;
  logic [5:0]  output_a_level;
  logic [5:0]  output_b_level;
  logic        output_a_on;
  logic        output_b_on;
  logic        calibrate_start;
  logic        align_event;
  logic        phase_aligned;
  int          num_errors  = 0;
  int          compares    = 0;
  int          n_cal       = 0;
  int          n_align     = 0;
  int          base;
  logic [15:0] d;
  int          tot [13]    = '{2, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192};

  always #5 sys_clk = ~sys_clk;

  // pulse counters catch one-cycle outputs without guessing the exact cycle
  always @(posedge sys_clk)
  begin
    if (calibrate_start === 1'b1) n_cal++;
    if (align_event === 1'b1) n_align++;
  end

  output_divider_and_phase_align #(.SETTLE(SETTLE_TB)) i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enable_pin(enable_pin),
    .sync_pin(sync_pin), .reference_clock_in(reference_clock_in),
    .device_active(device_active), .divider_powered(divider_powered),
    .divider_select(divider_select), .divide_total(divide_total),
    .select_valid(select_valid), .feedback_extra_divide(feedback_extra_divide),
    .output_a_level(output_a_level), .output_a_on(output_a_on),
    .output_b_level(output_b_level), .output_b_on(output_b_on),
    .calibrate_start(calibrate_start), .align_event(align_event),
    .phase_aligned(phase_aligned));

  ref_osc_model i_ref (
    .sync_req(sync_req), .reference_clock_in(reference_clock_in), .sync_pin(sync_pin));

  // ----------------------------------------------------------------
  // access and check tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  function automatic logic [15:0] outv(input logic [1:0] s, input logic dis,
                                       input logic [5:0] lvl);
    return {7'h00, s, dis, lvl};
  endfunction

  function automatic logic [15:0] exd(input int t);
    return (t % 3 == 0 && t != 24 && t != 192) ? 16'h0006 : 16'h0004;
  endfunction

  task automatic print_verdict;
    $display("Counts: %0d compares, %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    cyc(3);
    resetn <= 1'b1;
    rd(CTRL_OFS, d);
    check(d, CTRL_RST);
    rd(OUT_A_OFS, d);
    check(d, OUT_RST);
    rd(OUT_B_OFS, d);
    check(d, OUT_RST);
    rd(DIV_OFS, d);
    check(d, DIV_RST);
    rd(8'h20, d);
    check(d, 16'h0000);
    $display("test reset done");
    wr(CTRL_OFS, 16'h0004);
    cyc(3);
    check(16'(n_align), 16'h0001);
    cyc(SETTLE_TB + 8);
    check({15'h0, phase_aligned}, 16'h0001);
    wr(OUT_A_OFS, outv(SRC_DIVIDER, 1'b0, 6'h1f));
    for (int c = 0; c < 32; c++)
    begin
      wr(DIV_OFS, {11'h000, 5'(c)});
      cyc(2);
      rd(STATUS_OFS, d);
      check({11'h0, divider_select}, 16'(c));
      check({15'h0, select_valid}, {15'h0, c < 13});
      check({15'h0, d[1]}, {15'h0, c < 13});
      if (c < 13)
      begin
        check({8'h0, divide_total}, 16'(tot[c]));
        check({8'h0, d[15:8]}, 16'(tot[c]));
        check({13'h0, feedback_extra_divide}, exd(tot[c]));
      end
      else
        check({13'h0, feedback_extra_divide}, 16'h0004);
    end
    wr(OUT_A_OFS, outv(SRC_VCO, 1'b0, 6'h1f));
    wr(DIV_OFS, 16'h000c);
    cyc(2);
    check({13'h0, feedback_extra_divide}, 16'h0001);
    $display("test decode done");
    wr(CTRL_OFS, 16'h0006);
    for (int s = 0; s < 16; s++)
    begin
      wr(OUT_A_OFS, outv(s[3:2], 1'b0, 6'h1f));
      wr(OUT_B_OFS, outv(s[1:0], 1'b0, 6'h1f));
      cyc(2);
      check({15'h0, divider_powered},
            {15'h0, s[3:2] == 2'h0 || s[1:0] == 2'h0 || s[1:0] == 2'h2});
    end
    wr(OUT_A_OFS, OUT_RST);
    wr(OUT_B_OFS, OUT_RST);
    cyc(2);
    check({14'h0, divider_powered, device_active}, 16'h0000);
    $display("test power select done");
    wr(CTRL_OFS, 16'h0004);
    cyc(4);
    rd(STATUS_OFS, d);
    check({14'h0, d[3:2]}, 16'h0003);
    base = n_cal;
    wr(CTRL_OFS, 16'h0005);
    wr(CTRL_OFS, 16'h0005);
    cyc(2);
    check(16'(n_cal - base), 16'h0002);
    rd(STATUS_OFS, d);
    check({15'h0, d[3]}, 16'h0000);
    @(posedge sys_clk);
    enable_pin <= 1'b0;
    cyc(6);
    check({15'h0, device_active}, 16'h0000);
    enable_pin <= 1'b1;
    cyc(6);
    rd(STATUS_OFS, d);
    check({14'h0, d[3:2]}, 16'h0003);
    base = n_cal;
    wr(CTRL_OFS, 16'h0005);
    cyc(2);
    check(16'(n_cal - base), 16'h0001);
    $display("test power down done");
    base = n_cal;
    wr(OUT_B_OFS, outv(SRC_VCO, 1'b0, 6'h14));
    cyc(2);
    check({10'h0, output_b_level}, 16'h0014);
    check({10'h0, output_a_level}, 16'h001f);
    wr(OUT_B_OFS, outv(SRC_VCO, 1'b1, 6'h14));
    cyc(2);
    check({13'h0, output_b_on, output_a_on, device_active}, 16'h0003);
    check(16'(n_cal - base), 16'h0000);
    $display("test levels done");
    wr(DIV_OFS, 16'h0000);
    base = n_align;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge sys_clk);
      sync_req <= 1'b1;
      @(negedge reference_clock_in);
      #1;
      check(16'(n_align - base), 16'(i));
      @(posedge reference_clock_in);
      cyc(6);
      check(16'(n_align - base), 16'(i + 1));
      sync_req <= 1'b0;
      cyc(30);
    end
    wr(DIV_OFS, 16'h0020);
    base = n_align;
    sync_req <= 1'b1;
    cyc(30);
    sync_req <= 1'b0;
    cyc(30);
    check(16'(n_align - base), 16'h0000);
    rd(EVCOUNT_OFS, d);
    check(d, 16'h0003);
    wr(CTRL_OFS, 16'h0000);
    $display("test sync done");
    print_verdict;
  end

  initial
  begin
    #200000;
    num_errors++;
    print_verdict;
  end
endmodule // output_divider_and_phase_align_tb_top
`default_nettype wire
